//--- src/lms_pkg.sv
// Constants, register map and types of the line multiframe status block.
package lms_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int NIB_W = 4;
	localparam int CNT_W = 2;
	localparam int EVT_W = 3;

	// Register byte offsets.
	localparam logic [ADDR_W-1:0] OFS_MF_RX = 8'h34;
	localparam logic [ADDR_W-1:0] OFS_LINE_STATUS = 8'h35;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h36;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h37;
	localparam logic [ADDR_W-1:0] OFS_MF_TX = 8'h38;

	// Field positions of the multiframe receive register.
	localparam int MF_RX_NIB_LSB = 0;
	localparam int MF_RX_RDY_BIT = 4;
	localparam int MF_RX_SBIT_BIT = 6;
	localparam int MF_TX_RDY_BIT = 7;

	// Field positions of the line status register.
	localparam int LS_HIGH_CNT_BIT = 0;
	localparam int LS_LOW_CNT_BIT = 1;
	localparam int LS_CONT_BIT = 2;
	localparam int LS_ACT_BIT = 3;
	localparam int LS_FSYNC_BIT = 7;

	// Event positions in interrupt status and mask.
	localparam int EVT_RX_RDY = 0;
	localparam int EVT_TX_RDY = 1;
	localparam int EVT_CONT = 2;

	// Reset values, last count and count step.
	localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
	localparam logic [NIB_W-1:0] RST_NIB = 4'h0;
	localparam logic [CNT_W-1:0] RST_CNT = 2'h0;
	localparam logic [CNT_W-1:0] LAST_CNT = 2'h3;
	localparam logic [CNT_W-1:0] CNT_STEP = 2'h1;
	localparam logic [EVT_W-1:0] RST_EVT = 3'h0;

	typedef enum logic [1:0] {
		COL_HUNT = 2'b01,
		COL_RUN = 2'b10
	} lms_col_state_t;
endpackage : lms_pkg

//--- src/lms_evt_if.sv
// Event and interrupt signals between the top and the interrupt unit.
`timescale 1ns/1ps
interface lms_evt_if;
	logic [lms_pkg::EVT_W-1:0] evt;
	logic [lms_pkg::EVT_W-1:0] status;
	logic status_rd;
	logic mask_wr;
	logic [lms_pkg::EVT_W-1:0] mask_wdata;
	logic [lms_pkg::EVT_W-1:0] mask;
	logic irq;

	modport top (
		output evt,
		output status_rd,
		output mask_wr,
		output mask_wdata,
		input status,
		input mask,
		input irq
	);

	modport unit (
		input evt,
		input status_rd,
		input mask_wr,
		input mask_wdata,
		output status,
		output mask,
		output irq
	);
endinterface : lms_evt_if

//--- src/lms_irq.sv
// Sticky interrupt status, mask and level interrupt output.
`timescale 1ns/1ps
module lms_irq (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_ce,
	// Events and software side.
	lms_evt_if.unit ev
);
	import lms_pkg::*;

	typedef struct packed {
		logic [EVT_W-1:0] status;
		logic [EVT_W-1:0] mask;
	} lms_irq_state_t;

	lms_irq_state_t st;
	lms_irq_state_t next_st;

	always_comb
	begin
		next_st = st;
		// A read clears, but an event in the same cycle survives it.
		if (ev.status_rd)
		begin
			next_st.status = RST_EVT;
		end
		next_st.status = next_st.status | ev.evt;
		if (ev.mask_wr)
		begin
			next_st.mask = ev.mask_wdata;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			st <= '0;
		end
		else if (i_ce)
		begin
			st <= next_st;
		end
	end

	assign ev.status = st.status;
	assign ev.mask = st.mask;
	assign ev.irq = |(st.status & st.mask);
endmodule : lms_irq

//--- src/lms_collect.sv
// Serial collector that gathers four maintenance bits into one nibble.
`timescale 1ns/1ps
module lms_collect (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_ce,
	// Serial maintenance bits.
	input wire logic i_bit_valid,
	input wire logic i_bit_first,
	input wire logic i_bit,
	// Collected nibble.
	output logic [lms_pkg::NIB_W-1:0] o_nibble,
	output logic o_done
);
	import lms_pkg::*;

	typedef struct packed {
		lms_col_state_t state;
		logic [CNT_W-1:0] cnt;
		logic [NIB_W-1:0] shift;
		logic [NIB_W-1:0] nibble;
		logic done;
	} lms_col_t;

	lms_col_t st;
	lms_col_t next_st;

	always_comb
	begin
		next_st = st;
		next_st.done = 1'b0;
		case (st.state)
			COL_HUNT:
			begin
				// Only a first-bit marker can align the nibble.
				if (i_bit_valid && i_bit_first)
				begin
					next_st.shift = {RST_NIB[NIB_W-2:0], i_bit};
					next_st.cnt = CNT_STEP;
					next_st.state = COL_RUN;
				end
			end
			COL_RUN:
			begin
				if (i_bit_valid)
				begin
					if (i_bit_first)
					begin
						next_st.shift = {RST_NIB[NIB_W-2:0], i_bit};
						next_st.cnt = CNT_STEP;
					end
					else
					begin
						next_st.shift = {st.shift[NIB_W-2:0], i_bit};
						next_st.cnt = st.cnt + CNT_STEP;
						if (st.cnt == LAST_CNT)
						begin
							next_st.nibble = {st.shift[NIB_W-2:0], i_bit};
							next_st.done = 1'b1;
							next_st.state = COL_HUNT;
						end
					end
				end
			end
			default:
			begin
				next_st.state = COL_HUNT;
				next_st.cnt = RST_CNT;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			st <= '{state: COL_HUNT, cnt: RST_CNT, shift: RST_NIB, nibble: RST_NIB, done: 1'b0};
		end
		else if (i_ce)
		begin
			st <= next_st;
		end
	end

	assign o_nibble = st.nibble;
	assign o_done = st.done & i_ce;
endmodule : lms_collect

//--- src/lms_line_status.sv
// Multiframe receive and line status registers of the line interface.
`timescale 1ns/1ps
// Functional notes
// [R01] In S/T mode the four received S bits (terminal) or Q bits (network) fill bits 3..0.
// [R02] In Up mode bits 3..0 hold the T bits of two superframes ordered T1a, T1b, T2a, T2b.
// [R03] In S/T mode bit 4 goes to 1 when a whole S or Q multiframe is collected; reset is 0.
// [R04] In Up mode bit 4 goes to 1 only after two whole T superframes have arrived.
// [R05] Reading the multiframe receive register clears the receive-ready flag.
// [R06] Bit 6 holds the last received Up S-bit in Up mode and has no meaning in S/T mode.
// [R07] The received Up S-bit is also handed to the D- and E-channel receive registers.
// [R08] In S/T mode bit 7 goes to 1 when a new multiframe may be loaded; reset is 0.
// [R09] In Up mode bit 7 goes to 1 when two new T superframes may be loaded.
// [R10] Any write to the multiframe transmit register clears the transmit-ready flag; a framer take in the same cycle sets it instead.
// [R11] Only the frame-sync selection bit of line status counts in both modes.
// [R12] With the high priority class, status bit 0 shows eight (0) or nine (1) ones needed.
// [R13] With the low priority class, status bit 1 shows ten (0) or eleven (1) ones needed.
// [R14] Status bit 2 is 1 when D and echoed E bits differed in the last frame.
// [R15] Status bit 3 is 1 while the D-channel is transmitting, in S/T mode.
// [R16] In Up mode the S/T-only status bits and reserved bits 4 to 6 read as zero.
module lms_line_status (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_ce,
	// Register port.
	input wire logic [lms_pkg::ADDR_W-1:0] i_addr,
	input wire logic [lms_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [lms_pkg::DATA_W-1:0] o_rdata,
	// Line mode.
	input wire logic i_up_mode,
	input wire logic i_frame_sync_select,
	// Received maintenance bits from the framer.
	input wire logic i_mbit_valid,
	input wire logic i_mbit_first,
	input wire logic i_mbit,
	input wire logic i_up_sbit_valid,
	input wire logic i_up_sbit,
	// Transmit maintenance slot.
	input wire logic i_mf_tx_taken,
	output logic [lms_pkg::NIB_W-1:0] o_mf_tx_nibble,
	output logic o_mf_tx_load,
	// S-bit copy towards D- and E-channel receive registers.
	output logic o_sbit_copy,
	output logic o_sbit_copy_valid,
	// D-channel access state.
	input wire logic i_priority_class_select,
	input wire logic i_prio_raised,
	input wire logic i_dbit_strobe,
	input wire logic i_dtx_bit,
	input wire logic i_echo_bit,
	input wire logic i_frame_end,
	input wire logic i_dchan_transmitting,
	// Interrupt.
	output logic o_irq
);
	import lms_pkg::*;

	typedef struct packed {
		logic [DATA_W-1:0] rdata;
		logic [NIB_W-1:0] received_maint_bits;
		logic maint_rx_ready;
		logic maint_tx_ready;
		logic up_sbit;
		logic sbit_copy;
		logic sbit_copy_valid;
		logic cont_acc;
		logic dchan_contention;
		logic [NIB_W-1:0] tx_nibble;
		logic tx_load;
	} lms_top_t;

	lms_top_t st;
	lms_top_t next_st;
	lms_evt_if ev ();

	logic [NIB_W-1:0] col_nibble;
	logic col_done;
	logic rd_mf_rx;
	logic wr_mf_tx;
	logic mismatch;
	logic [DATA_W-1:0] mf_rx_view;
	logic [DATA_W-1:0] line_status_view;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	function automatic logic [DATA_W-1:0] widen(input logic [EVT_W-1:0] v);
		widen = {{(DATA_W-EVT_W){1'b0}}, v};
	endfunction : widen

	// [R01] [R02] Four bits collected in framer order, first bit lands in bit 3.
	lms_collect u_collect (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_ce(i_ce),
		.i_bit_valid(i_mbit_valid),
		.i_bit_first(i_mbit_first),
		.i_bit(i_mbit),
		.o_nibble(col_nibble),
		.o_done(col_done)
	);

	lms_irq u_irq (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_ce(i_ce),
		.ev(ev.unit)
	);

	assign rd_mf_rx = i_rd && hit(i_addr, OFS_MF_RX);
	assign wr_mf_tx = i_wr && hit(i_addr, OFS_MF_TX);
	// [R14] Compared only while we drive D; echoes of others' frames mean nothing.
	assign mismatch = i_dbit_strobe && i_dchan_transmitting && (i_dtx_bit != i_echo_bit);

	always_comb
	begin
		mf_rx_view = RST_BYTE;
		mf_rx_view[MF_RX_NIB_LSB +: NIB_W] = st.received_maint_bits;
		mf_rx_view[MF_RX_RDY_BIT] = st.maint_rx_ready;
		// [R06] S-bit shown in Up mode only, zero in S/T mode.
		mf_rx_view[MF_RX_SBIT_BIT] = i_up_mode & st.up_sbit;
		mf_rx_view[MF_TX_RDY_BIT] = st.maint_tx_ready;
	end

	always_comb
	begin
		line_status_view = RST_BYTE;
		// [R11] Frame-sync selection shown in both modes.
		line_status_view[LS_FSYNC_BIT] = i_frame_sync_select;
		// [R16] Up mode masks every S/T-only bit to zero.
		if (!i_up_mode)
		begin
			// [R12] High class count state.
			line_status_view[LS_HIGH_CNT_BIT] = !i_priority_class_select & i_prio_raised;
			// [R13] Low class count state.
			line_status_view[LS_LOW_CNT_BIT] = i_priority_class_select & i_prio_raised;
			// [R14] Contention from the last frame.
			line_status_view[LS_CONT_BIT] = st.dchan_contention;
			// [R15] D-channel activity.
			line_status_view[LS_ACT_BIT] = i_dchan_transmitting;
		end
	end

	always_comb
	begin
		next_st = st;
		next_st.sbit_copy_valid = 1'b0;
		next_st.tx_load = 1'b0;
		next_st.rdata = RST_BYTE;
		if (i_rd)
		begin
			if (hit(i_addr, OFS_MF_RX))
			begin
				next_st.rdata = mf_rx_view;
			end
			else if (hit(i_addr, OFS_LINE_STATUS))
			begin
				next_st.rdata = line_status_view;
			end
			else if (hit(i_addr, OFS_IRQ_STATUS))
			begin
				next_st.rdata = widen(ev.status);
			end
			else if (hit(i_addr, OFS_IRQ_MASK))
			begin
				next_st.rdata = widen(ev.mask);
			end
		end
		// [R05] Read clears the ready flag; a completion in the same cycle wins.
		if (rd_mf_rx)
		begin
			next_st.maint_rx_ready = 1'b0;
		end
		// [R03] [R04] Ready once a multiframe or superframe pair is complete.
		if (col_done)
		begin
			next_st.received_maint_bits = col_nibble;
			next_st.maint_rx_ready = 1'b1;
		end
		// [R10] Writing the transmit register clears transmit-ready; a take in the same cycle wins.
		if (wr_mf_tx)
		begin
			next_st.maint_tx_ready = 1'b0;
			next_st.tx_nibble = i_wdata[NIB_W-1:0];
			next_st.tx_load = 1'b1;
		end
		// [R08] [R09] Framer took the previous nibble, room for a new one.
		if (i_mf_tx_taken)
		begin
			next_st.maint_tx_ready = 1'b1;
		end
		// [R06] [R07] Latest S-bit kept and forwarded to D and E receive.
		if (i_up_sbit_valid && i_up_mode)
		begin
			next_st.up_sbit = i_up_sbit;
			next_st.sbit_copy = i_up_sbit;
			next_st.sbit_copy_valid = 1'b1;
		end
		// [R14] Frame end publishes the accumulated mismatch, current bit included.
		if (i_frame_end)
		begin
			next_st.dchan_contention = st.cont_acc | mismatch;
			next_st.cont_acc = 1'b0;
		end
		else if (mismatch)
		begin
			next_st.cont_acc = 1'b1;
		end
	end

	always_comb
	begin
		ev.evt = RST_EVT;
		ev.evt[EVT_RX_RDY] = col_done;
		ev.evt[EVT_TX_RDY] = i_mf_tx_taken;
		ev.evt[EVT_CONT] = i_frame_end & (st.cont_acc | mismatch) & !i_up_mode;
		ev.status_rd = i_rd && hit(i_addr, OFS_IRQ_STATUS);
		ev.mask_wr = i_wr && hit(i_addr, OFS_IRQ_MASK);
		ev.mask_wdata = i_wdata[EVT_W-1:0];
	end

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			st <= '0;
		end
		else if (i_ce)
		begin
			st <= next_st;
		end
	end

	assign o_rdata = st.rdata;
	assign o_mf_tx_nibble = st.tx_nibble;
	assign o_mf_tx_load = st.tx_load;
	assign o_sbit_copy = st.sbit_copy;
	assign o_sbit_copy_valid = st.sbit_copy_valid;
	assign o_irq = ev.irq;
endmodule : lms_line_status

//--- sim/lms_far.sv
// Model of the remote line side that feeds the framer inputs.
`timescale 1ns/1ps
module lms_far (
	// Clock.
	input wire logic i_clk,
	// Line side.
	output logic o_mbit_valid,
	output logic o_mbit_first,
	output logic o_mbit,
	output logic o_sbit_valid,
	output logic o_sbit,
	output logic o_taken,
	output logic o_dstrobe,
	output logic o_dtx,
	output logic o_echo,
	output logic o_fend
);
	initial
	begin
		{o_mbit_valid, o_mbit_first, o_mbit, o_sbit_valid, o_sbit} = 5'h00;
		{o_taken, o_dstrobe, o_dtx, o_echo, o_fend} = 5'h00;
	end

	// Bits go first-marked, msb first; a released line flips so stale data never matches.
	task automatic nib(input logic [3:0] n, input int k);
		for (int i = 3; i > 3 - k; i--)
		begin
			o_mbit_valid <= 1'b1;
			o_mbit_first <= (i == 3);
			o_mbit <= n[i];
			@(posedge i_clk);
		end
		o_mbit_valid <= 1'b0;
		o_mbit <= ~o_mbit;
	endtask : nib

	task automatic sb(input logic b);
		o_sbit_valid <= 1'b1;
		o_sbit <= b;
		@(posedge i_clk);
		o_sbit_valid <= 1'b0;
		o_sbit <= ~b;
	endtask : sb

	task automatic take;
		o_taken <= 1'b1;
		@(posedge i_clk);
		o_taken <= 1'b0;
	endtask : take

	task automatic frame(input logic d, input logic e);
		o_dstrobe <= 1'b1;
		o_dtx <= d;
		o_echo <= e;
		@(posedge i_clk);
		o_dstrobe <= 1'b0;
		o_dtx <= ~d;
		o_echo <= ~e;
		o_fend <= 1'b1;
		@(posedge i_clk);
		o_fend <= 1'b0;
	endtask : frame
endmodule : lms_far

//--- sim/lms_line_status_chk.sv
// Checker of the register port and S-bit copy of the line status block.
`timescale 1ns/1ps
module lms_line_status_chk (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_ce,
	// Watched ports.
	input wire logic [lms_pkg::ADDR_W-1:0] i_addr,
	input wire logic [lms_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [lms_pkg::DATA_W-1:0] o_rdata,
	input wire logic i_up_mode,
	input wire logic i_frame_sync_select,
	input wire logic i_mbit_valid,
	input wire logic i_up_sbit_valid,
	input wire logic i_up_sbit,
	input wire logic i_mf_tx_taken,
	input wire logic [lms_pkg::NIB_W-1:0] o_mf_tx_nibble,
	input wire logic o_mf_tx_load,
	input wire logic o_sbit_copy,
	input wire logic o_sbit_copy_valid,
	input wire logic i_priority_class_select,
	input wire logic i_prio_raised,
	input wire logic i_dchan_transmitting
);
	import lms_pkg::*;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	sequence s_rd(a, g);
		i_ce && i_rd && i_addr == a && g;
	endsequence
	sequence s_wtx;
		i_ce && i_wr && i_addr == OFS_MF_TX;
	endsequence

	// A frozen cycle keeps the last read data, so only a running idle cycle counts.
	AST_RD_IDLE: assert property ($past(i_ce) && !$past(i_rd) |-> o_rdata == RST_BYTE)
		else $error("read data not zero outside a read");
	// A fourth bit one cycle before the first read completes at that read and may set again.
	AST_RX_CLR: assert property (!i_mbit_valid ##1 s_rd(OFS_MF_RX, 1'b1)
		##1 s_rd(OFS_MF_RX, 1'b1) |=> !o_rdata[MF_RX_RDY_BIT])
		else $error("receive ready survived a read");
	AST_TX_CLR: assert property (s_wtx ##0 !i_mf_tx_taken ##1 !i_mf_tx_taken
		##1 s_rd(OFS_MF_RX, !i_mf_tx_taken) |=> !o_rdata[MF_TX_RDY_BIT])
		else $error("transmit ready survived a write");
	AST_LS_FIX: assert property (s_rd(OFS_LINE_STATUS, 1'b1) |=> o_rdata[6:4] == 3'h0
		&& o_rdata[LS_FSYNC_BIT] == $past(i_frame_sync_select)) else $error("line status top bad");
	AST_LS_UP: assert property (s_rd(OFS_LINE_STATUS, i_up_mode) |=> o_rdata[3:0] == 4'h0)
		else $error("line status low bits not zero in Up mode");
	AST_LS_ACT: assert property (s_rd(OFS_LINE_STATUS, !i_up_mode)
		|=> o_rdata[LS_ACT_BIT] == $past(i_dchan_transmitting)) else $error("active bit bad");
	AST_LS_PRIO: assert property (s_rd(OFS_LINE_STATUS, !i_up_mode) |=>
		o_rdata[0] == ($past(i_prio_raised) && !$past(i_priority_class_select))
		&& o_rdata[1] == ($past(i_prio_raised) && $past(i_priority_class_select)))
		else $error("priority count bits bad");
	AST_MF_RSV: assert property (s_rd(OFS_MF_RX, !i_up_mode) |=> o_rdata[6:5] == 2'h0)
		else $error("bits 6 and 5 not zero in S/T mode");
	AST_TX_LOAD: assert property (s_wtx |=> o_mf_tx_load
		&& {4'h0, o_mf_tx_nibble} == ($past(i_wdata) & 8'h0F)) else $error("transmit load bad");
	AST_NO_LOAD: assert property (i_ce && !(i_wr && i_addr == OFS_MF_TX)
		|=> !o_mf_tx_load) else $error("spurious transmit load");
	AST_SBIT: assert property (i_ce && i_up_mode && i_up_sbit_valid |=> o_sbit_copy_valid
		&& o_sbit_copy == $past(i_up_sbit)) else $error("S-bit copy bad");
endmodule : lms_line_status_chk

bind lms_line_status lms_line_status_chk i_chk (.i_clk, .i_reset_n, .i_ce, .i_addr, .i_wdata,
	.i_wr, .i_rd, .o_rdata, .i_up_mode, .i_frame_sync_select, .i_mbit_valid, .i_up_sbit_valid,
	.i_up_sbit, .i_mf_tx_taken, .o_mf_tx_nibble, .o_mf_tx_load, .o_sbit_copy,
	.o_sbit_copy_valid, .i_priority_class_select, .i_prio_raised, .i_dchan_transmitting);

//--- sim/test_lms_line_status.sv
// Self-checking testbench of the line multiframe status block.
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
	$display("Error at %0t ns: got %h, expected %h", $time, (a), (e)); end end
module test_lms_line_status;
	import lms_pkg::*;
	logic i_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic i_ce = 1'b1;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [ADDR_W-1:0] i_addr = 8'h00;
	logic [DATA_W-1:0] i_wdata = 8'h00;
	logic i_up_mode = 1'b0;
	logic i_frame_sync_select = 1'b0;
	logic i_priority_class_select = 1'b0;
	logic i_prio_raised = 1'b0;
	logic i_dchan_transmitting = 1'b0;
	logic i_mbit_valid, i_mbit_first, i_mbit, i_up_sbit_valid, i_up_sbit, i_mf_tx_taken;
	logic i_dbit_strobe, i_dtx_bit, i_echo_bit, i_frame_end;
	logic [DATA_W-1:0] o_rdata;
	logic [NIB_W-1:0] o_mf_tx_nibble;
	logic o_mf_tx_load, o_sbit_copy, o_sbit_copy_valid, o_irq;
	int miscompares = 0;
	int num_checks = 0;
	int cycles = 0;

	always #12.5 i_clk = ~i_clk;

	lms_line_status i_dut (.i_clk, .i_reset_n, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
		.i_up_mode, .i_frame_sync_select, .i_mbit_valid, .i_mbit_first, .i_mbit,
		.i_up_sbit_valid, .i_up_sbit, .i_mf_tx_taken, .o_mf_tx_nibble, .o_mf_tx_load,
		.o_sbit_copy, .o_sbit_copy_valid, .i_priority_class_select, .i_prio_raised,
		.i_dbit_strobe, .i_dtx_bit, .i_echo_bit, .i_frame_end, .i_dchan_transmitting, .o_irq);

	lms_far i_far (.i_clk, .o_mbit_valid(i_mbit_valid), .o_mbit_first(i_mbit_first),
		.o_mbit(i_mbit), .o_sbit_valid(i_up_sbit_valid), .o_sbit(i_up_sbit),
		.o_taken(i_mf_tx_taken), .o_dstrobe(i_dbit_strobe), .o_dtx(i_dtx_bit),
		.o_echo(i_echo_bit), .o_fend(i_frame_end));

	task end_sim;
		$display("checks %0d, miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim

	// Every task starts and ends just after a rising edge.
	task rd(input logic [7:0] a, input logic [7:0] e);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		`CHK(o_rdata, e)
		@(posedge i_clk);
	endtask : rd

	task rd2(input logic [7:0] e1, input logic [7:0] e2);
		i_rd <= 1'b1;
		i_addr <= OFS_MF_RX;
		@(posedge i_clk);
		@(negedge i_clk);
		`CHK(o_rdata, e1)
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		`CHK(o_rdata, e2)
		@(posedge i_clk);
	endtask : rd2

	task wr(input logic [7:0] a, input logic [7:0] d);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
		@(negedge i_clk);
		`CHK(o_mf_tx_load, a == OFS_MF_TX)
		@(posedge i_clk);
	endtask : wr

	task t_st;
		wr(OFS_IRQ_MASK, 8'h01);
		i_far.nib(4'hB, 4);
		@(posedge i_clk);
		@(negedge i_clk);
		`CHK(o_irq, 1'b1)
		@(posedge i_clk);
		rd2(8'h1B, 8'h0B);
		rd(OFS_IRQ_STATUS, 8'h01);
		`CHK(o_irq, 1'b0)
		i_far.nib(4'h5, 3);
		rd(OFS_MF_RX, 8'h0B);
		$display("t_st done");
	endtask : t_st

	task t_up;
		i_up_mode <= 1'b1;
		@(posedge i_clk);
		i_far.sb(1'b1);
		@(negedge i_clk);
		`CHK({o_sbit_copy_valid, o_sbit_copy}, 2'h3)
		@(posedge i_clk);
		i_far.nib(4'hA, 2);
		rd(OFS_MF_RX, 8'h4B);
		i_far.nib(4'h6, 4);
		// This read meets the completion edge: it sees the old value and the set wins.
		rd(OFS_MF_RX, 8'h4B);
		rd(OFS_MF_RX, 8'h56);
		rd(OFS_IRQ_STATUS, 8'h01);
		$display("t_up done");
	endtask : t_up

	task t_tx;
		for (int m = 0; m < 2; m++)
		begin
			i_up_mode <= m[0];
			i_far.take();
			rd(OFS_MF_RX, {1'b1, m[0], 6'h06});
			wr(OFS_MF_TX, 8'hF9);
			`CHK(o_mf_tx_nibble, 4'h9)
			rd(OFS_MF_RX, {1'b0, m[0], 6'h06});
			rd(OFS_IRQ_STATUS, 8'h02);
		end
		$display("t_tx done");
	endtask : t_tx

	task t_ls;
		i_up_mode <= 1'b0;
		i_dchan_transmitting <= 1'b1;
		for (int c = 0; c < 2; c++)
			for (int r = 0; r < 2; r++)
			begin
				i_priority_class_select <= c[0];
				i_prio_raised <= r[0];
				@(posedge i_clk);
				rd(OFS_LINE_STATUS, {6'h02, c[0] & r[0], ~c[0] & r[0]});
			end
		i_far.frame(1'b1, 1'b0);
		rd(OFS_LINE_STATUS, 8'h0E);
		rd(OFS_IRQ_STATUS, 8'h04);
		i_far.frame(1'b1, 1'b1);
		rd(OFS_LINE_STATUS, 8'h0A);
		i_up_mode <= 1'b1;
		i_frame_sync_select <= 1'b1;
		@(posedge i_clk);
		wr(OFS_LINE_STATUS, 8'hFF);
		rd(OFS_LINE_STATUS, 8'h80);
		rd(8'h3F, 8'h00);
		rd(OFS_MF_TX, 8'h00);
		// A write while the clock enable is low must leave the mask alone.
		i_ce <= 1'b0;
		wr(OFS_IRQ_MASK, 8'h07);
		i_ce <= 1'b1;
		rd(OFS_IRQ_MASK, 8'h01);
		$display("t_ls done");
	endtask : t_ls

	// The whole run is about a hundred cycles, so this ceiling only trips on a hang.
	always @(posedge i_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			miscompares++;
			end_sim();
		end
	end

	initial
	begin
		repeat (8) @(posedge i_clk);
		i_reset_n <= 1'b1;
		@(posedge i_clk);
		rd(OFS_MF_RX, 8'h00);
		rd(OFS_LINE_STATUS, 8'h00);
		$display("t_reset done");
		t_st();
		t_up();
		t_tx();
		t_ls();
		end_sim();
	end
endmodule : test_lms_line_status
